// ### design/cti_fifo.v
// small flop fifo with valid/ready on both sides
`default_nettype none
module cti_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire [WIDTH-1:0] in_data_in,
	input wire in_valid_in,
	output wire in_ready_out,
	output wire [WIDTH-1:0] out_data_out,
	output wire out_valid_out,
	input wire out_ready_in
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;
	assign in_ready_out = (cnt_q != DEPTH[AW:0]);
	assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
	assign out_data_out = mem_q[rd_q];
	always @(posedge sys_clk_in) begin
		if (push)
			mem_q[wr_q] <= in_data_in;
	end
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // cti_fifo
`default_nettype wire

// ### design/cti_regs.vh
// constants for the cassette tape interface
`ifndef CTI_REGS_VH
`define CTI_REGS_VH
`define CTI_CMD_STATUS 3'b101
`define CTI_CMD_CONNECT 3'b010
`define CTI_CMD_OUT_XCHG 3'b100
`define CTI_CMD_IN_XCHG 3'b001
`define CTI_CMD_DISCONNECT 3'b111
`define CTI_FRAME_BYTE 8'haa
`define CTI_CRC_POLY 16'h8005
`define CTI_CRC_INIT 16'h0000
`define CTI_OP_READ 0
`define CTI_OP_CALL 1
`define CTI_OP_WRITE 2
`define CTI_OP_ERASE 4
`define CTI_OP_FWD 5
`define CTI_OP_REV 6
`define CTI_OP_RWD 7
`define CTI_CLK_HZ 20000000
`define CTI_HOST_CLK_HZ 1000000
`define CTI_HALF_CELL_HZ 24000
`define CTI_HALF_CELL_CYC (`CTI_CLK_HZ / `CTI_HALF_CELL_HZ)
`define CTI_GAP_MS 100
`define CTI_GAP_CYC (`CTI_CLK_HZ / 1000 * `CTI_GAP_MS)
`define CTI_READ_MASK_US 130
`define CTI_READ_MASK_CYC ((`CTI_CLK_HZ / 1000000) * `CTI_READ_MASK_US)
`endif

// ### design/cti_top.v
// cassette tape interface: host i/o port, block framer, phase encoder and reader
`default_nettype none
`include "cti_regs.vh"
module cti_top #(
	parameter [4:0] DEV_ADDR = 5'h05,
	parameter GAP_CYC = `CTI_GAP_CYC,
	parameter HALF_CYC = `CTI_HALF_CELL_CYC,
	parameter MASK_CYC = `CTI_READ_MASK_CYC
) (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire op_request_n_in,
	output wire op_ack_n_out,
	output wire irq_n_out,
	input wire ext_io_sel_n_in,
	input wire [7:0] host_addr_lo_in,
	input wire [7:0] host_data_in,
	output wire [7:0] host_data_out,
	output wire host_data_oe_out,
	input wire [8:0] first_len_in,
	input wire [7:0] block_count_in,
	input wire tape_mark_in,
	output wire cassette_lock_out,
	output wire drive_select_out,
	output wire tape_forward_out,
	output wire tape_backward_out,
	output wire write_command_out,
	output wire read_gate_out,
	output wire tape_rewind_out,
	output wire write_data_line_out,
	input wire side_indicator_in,
	input wire write_enable_n_in,
	input wire ready_n_in,
	input wire tape_end_marker_n_in,
	input wire read_data_line_in,
	output wire crc_error_out,
	output wire busy_out
);
	// crc step over one bit, shared by write and read paths
	function [15:0] crc_bit;
		input [15:0] c;
		input b;
		begin
			crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CTI_CRC_POLY : 16'h0000);
		end
	endfunction

	localparam ST_IDLE = 3'd0;
	localparam ST_PRE = 3'd1;
	localparam ST_DATA = 3'd2;
	localparam ST_CRC1 = 3'd3;
	localparam ST_CRC2 = 3'd4;
	localparam ST_POST = 3'd5;
	localparam ST_GAP = 3'd6;

	// two-flop synchronisers for drive status and read data
	reg [4:0] sync1_q;
	reg [4:0] sync2_q;
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1_q <= 5'h1f;
			sync2_q <= 5'h1f;
		end else begin
			sync1_q <= {read_data_line_in, tape_end_marker_n_in, ready_n_in, write_enable_n_in, side_indicator_in};
			sync2_q <= sync1_q;
		end
	end
	wire side_s = sync2_q[0];
	wire wen_n_s = sync2_q[1];
	wire rdy_n_s = sync2_q[2];
	wire bet_n_s = sync2_q[3];
	wire rda_s = sync2_q[4];

	wire sel = !ext_io_sel_n_in && !op_request_n_in && (host_addr_lo_in[4:0] == DEV_ADDR);
	wire [2:0] cmd = host_addr_lo_in[7:5];
	reg sel_d1_q;
	assign op_ack_n_out = !sel;
	wire act = sel && !sel_d1_q;
	wire do_stat = act && cmd == `CTI_CMD_STATUS;
	wire do_cx = act && cmd == `CTI_CMD_CONNECT;
	wire do_oec = act && cmd == `CTI_CMD_OUT_XCHG;
	wire do_iec = act && cmd == `CTI_CMD_IN_XCHG;
	wire do_dx = act && cmd == `CTI_CMD_DISCONNECT;

	reg [7:0] op_q;
	reg call_q;
	reg [7:0] rd_byte_q;
	reg [7:0] dout_q;
	reg gap_q;
	reg crc_err_q;
	// gap indicator shows no data read from tape since reset
	wire [7:0] status_w = {bet_n_s, gap_q, 1'b0, !rdy_n_s, 2'b00, wen_n_s, side_s};

	wire fifo_in_ready;
	wire [7:0] fifo_data;
	wire fifo_valid;
	wire fifo_pop;

	cti_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.in_data_in(host_data_in),
		.in_valid_in(do_oec),
		.in_ready_out(fifo_in_ready),
		.out_data_out(fifo_data),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop)
	);

	// write path
	reg [2:0] st_q;
	reg [8:0] left_q;
	reg [7:0] blocks_q;
	reg [7:0] sh_q;
	reg [2:0] bit_q;
	reg [15:0] crc_q;
	reg half_q;
	reg prev_bit_q;
	reg wda_q;
	reg [12:0] div_q;
	reg [23:0] gap_cnt_q;
	wire tick = (div_q == HALF_CYC - 1);
	wire byte_end = tick && half_q && (bit_q == 3'd7);
	wire write_on = op_q[`CTI_OP_WRITE] && !wen_n_s;
	wire start = write_on && st_q == ST_IDLE && (fifo_valid || tape_mark_in);
	wire need_data = (st_q == ST_PRE || st_q == ST_DATA) && !tape_mark_in && left_q != 9'd0;
	assign fifo_pop = byte_end && need_data && fifo_valid;
	wire write_char_done = byte_end;
	// last data bit folds in on the same edge that loads the crc byte
	wire [15:0] crc_next = crc_bit(crc_q, sh_q[0]);

	// next character source by frame phase
	reg [7:0] next_byte;
	reg [2:0] next_st;
	always @* begin
		next_byte = `CTI_FRAME_BYTE;
		next_st = st_q;
		case (st_q)
			ST_PRE, ST_DATA: begin
				if (tape_mark_in) begin
					next_byte = 8'h00;
					next_st = (st_q == ST_PRE) ? ST_DATA : ST_CRC2;
				end else if (left_q != 9'd0) begin
					next_byte = fifo_data;
					next_st = ST_DATA;
				end else begin
					next_byte = crc_next[15:8];
					next_st = ST_CRC1;
				end
			end
			ST_CRC1: begin
				next_byte = crc_q[7:0];
				next_st = ST_CRC2;
			end
			ST_CRC2: begin
				next_byte = `CTI_FRAME_BYTE;
				next_st = ST_POST;
			end
			ST_POST: begin
				next_byte = 8'h00;
				next_st = ST_GAP;
			end
			default: begin
				next_byte = `CTI_FRAME_BYTE;
				next_st = st_q;
			end
		endcase
	end

	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= ST_IDLE;
			left_q <= 9'd0;
			blocks_q <= 8'd0;
			sh_q <= 8'h00;
			bit_q <= 3'd0;
			crc_q <= `CTI_CRC_INIT;
			half_q <= 1'b0;
			prev_bit_q <= 1'b0;
			wda_q <= 1'b1;
			div_q <= 13'd0;
			gap_cnt_q <= 24'd0;
		end else begin
			div_q <= tick ? 13'd0 : div_q + 13'd1;
			if (start) begin
				st_q <= ST_PRE;
				sh_q <= `CTI_FRAME_BYTE;
				bit_q <= 3'd0;
				half_q <= 1'b0;
				crc_q <= `CTI_CRC_INIT;
				left_q <= first_len_in;
				blocks_q <= block_count_in;
			end else if (st_q == ST_GAP) begin
				gap_cnt_q <= gap_cnt_q + 24'd1;
				if (gap_cnt_q == GAP_CYC - 1) begin
					gap_cnt_q <= 24'd0;
					if (blocks_q > 8'd1 && write_on) begin
						blocks_q <= blocks_q - 8'd1;
						left_q <= 9'd256;
						st_q <= ST_PRE;
						sh_q <= `CTI_FRAME_BYTE;
						bit_q <= 3'd0;
						half_q <= 1'b0;
						crc_q <= `CTI_CRC_INIT;
					end else
						st_q <= ST_IDLE;
				end
			end else if (st_q != ST_IDLE && tick) begin
				half_q <= !half_q;
				if (!half_q) begin
					if (sh_q[0] == prev_bit_q)
						wda_q <= !wda_q;
				end else begin
					wda_q <= sh_q[0];
					prev_bit_q <= sh_q[0];
					if (st_q == ST_DATA || (st_q == ST_CRC1 && bit_q == 3'd0 && 1'b0))
						crc_q <= crc_bit(crc_q, sh_q[0]);
					bit_q <= bit_q + 3'd1;
					sh_q <= {1'b0, sh_q[7:1]};
					if (byte_end) begin
						sh_q <= next_byte;
						st_q <= next_st;
						if (need_data)
							left_q <= left_q - 9'd1;
					end
				end
			end
		end
	end

	// read path: mask phase transitions after each bit edge
	reg rda_d_q;
	reg [12:0] mask_q;
	reg [7:0] rsh_q;
	reg [2:0] rbit_q;
	reg [15:0] rcrc_q;
	wire redge = (rda_s != rda_d_q) && mask_q == 13'd0 && op_q[`CTI_OP_READ];
	wire read_char_done = redge && rbit_q == 3'd7;
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rda_d_q <= 1'b1;
			mask_q <= 13'd0;
			rsh_q <= 8'h00;
			rbit_q <= 3'd0;
			rcrc_q <= `CTI_CRC_INIT;
			rd_byte_q <= 8'h00;
			gap_q <= 1'b1;
			crc_err_q <= 1'b0;
		end else begin
			rda_d_q <= rda_s;
			if (mask_q != 13'd0)
				mask_q <= mask_q - 13'd1;
			if (!op_q[`CTI_OP_READ]) begin
				rbit_q <= 3'd0;
				rcrc_q <= `CTI_CRC_INIT;
			end else if (redge) begin
				mask_q <= MASK_CYC[12:0];
				gap_q <= 1'b0;
				rsh_q <= {rda_s, rsh_q[7:1]};
				rbit_q <= rbit_q + 3'd1;
				rcrc_q <= crc_bit(rcrc_q, rda_s);
				if (read_char_done)
					rd_byte_q <= {rda_s, rsh_q[7:1]};
			end
			if (do_cx)
				crc_err_q <= 1'b0;
			else if (do_dx && op_q[`CTI_OP_READ] && rcrc_q != 16'h0000)
				crc_err_q <= 1'b1;
		end
	end

	// operation word, call flop and data out
	// reset clears controls
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			op_q <= 8'h00;
			call_q <= 1'b0;
			dout_q <= 8'h00;
			sel_d1_q <= 1'b0;
		end else begin
			sel_d1_q <= sel;
			if (do_cx)
				op_q <= host_data_in;
			else if (do_dx)
				op_q <= {op_q[7], 7'h00};
			// rewind ends at tape marker
			if (!bet_n_s)
				op_q[`CTI_OP_RWD] <= 1'b0;
			if ((write_char_done && st_q == ST_DATA) || read_char_done || (do_cx && host_data_in[`CTI_OP_CALL]))
				call_q <= 1'b1;
			else if (do_dx || do_oec || do_iec)
				call_q <= 1'b0;
			if (do_iec)
				dout_q <= rd_byte_q;
			else if (do_stat)
				dout_q <= status_w;
		end
	end

	assign host_data_out = dout_q;
	assign host_data_oe_out = sel && (cmd == `CTI_CMD_IN_XCHG || cmd == `CTI_CMD_STATUS) && sel_d1_q;
	assign irq_n_out = !call_q;
	assign cassette_lock_out = op_q != 8'h00;
	assign drive_select_out = op_q != 8'h00;
	assign tape_forward_out = op_q[`CTI_OP_FWD];
	assign tape_backward_out = op_q[`CTI_OP_REV];
	assign tape_rewind_out = op_q[`CTI_OP_RWD];
	assign write_command_out = op_q[`CTI_OP_WRITE] || op_q[`CTI_OP_ERASE];
	assign read_gate_out = op_q[`CTI_OP_READ];
	// erase holds the line high
	assign write_data_line_out = wda_q || op_q[`CTI_OP_ERASE];
	assign crc_error_out = crc_err_q;
	// busy only while the fifo would refuse a byte, so the host can feed a running block
	assign busy_out = !fifo_in_ready;
endmodule // cti_top
`default_nettype wire

// ### dv/cti_chk_sva.sv
// port assertions for the cassette tape interface
`default_nettype none
`include "cti_regs.vh"
module cti_chk_sva #(
	parameter [4:0] DEV_ADDR = 5'h05
) (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic op_request_n_in,
	input wire logic ext_io_sel_n_in,
	input wire logic [7:0] host_addr_lo_in,
	input wire logic [7:0] host_data_in,
	input wire logic op_ack_n_out,
	input wire logic host_data_oe_out,
	input wire logic irq_n_out,
	input wire logic cassette_lock_out,
	input wire logic drive_select_out,
	input wire logic tape_forward_out,
	input wire logic tape_backward_out,
	input wire logic read_gate_out,
	input wire logic write_command_out,
	input wire logic crc_error_out
);
	wire logic [2:0] cmd = host_addr_lo_in[7:5];
	wire logic hit = !op_request_n_in && !ext_io_sel_n_in && host_addr_lo_in[4:0] == DEV_ADDR;
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence cx_s;
		$fell(op_ack_n_out) && cmd == `CTI_CMD_CONNECT;
	endsequence
	sequence dx_s;
		$fell(op_ack_n_out) && cmd == `CTI_CMD_DISCONNECT;
	endsequence
	ack_cause_a: assert property (!op_ack_n_out |-> hit) else $error("stray ack");
	ack_match_a: assert property (hit |-> !op_ack_n_out) else $error("missing ack");
	oe_read_a: assert property (host_data_oe_out |-> !op_ack_n_out &&
		(cmd == `CTI_CMD_STATUS || cmd == `CTI_CMD_IN_XCHG)) else $error("bad bus drive");
	lock_select_a: assert property (cassette_lock_out |-> drive_select_out) else $error("lock alone");
	connect_ctl_a: assert property (cx_s |=> tape_forward_out == $past(host_data_in[5]) &&
		tape_backward_out == $past(host_data_in[6]) && read_gate_out == $past(host_data_in[0]))
		else $error("op word not applied");
	disc_clear_a: assert property (dx_s |=> !tape_forward_out && !tape_backward_out &&
		!read_gate_out && !write_command_out && irq_n_out) else $error("disconnect left controls");
	crc_clear_a: assert property (cx_s |=> !crc_error_out) else $error("crc flag kept");
	reset_idle_a: assert property ($rose(reset_n_in) |-> irq_n_out && !cassette_lock_out &&
		!write_command_out) else $error("reset state");
endmodule // cti_chk_sva
bind cti_top cti_chk_sva #(.DEV_ADDR(DEV_ADDR)) cti_chk_sva_inst (.*);
`default_nettype wire

// ### dv/cti_drive_model.sv
// drive model: status lines and a phase decoder on the write line
`default_nettype none
module cti_drive_model #(
	parameter int HALF = 8,
	parameter int GAP = 200
) (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic lock_in,
	input wire logic select_in,
	input wire logic write_data_line_in,
	output logic side_out,
	output logic write_enable_n_out,
	output logic ready_n_out,
	output logic tape_end_n_out,
	output logic read_data_line_out,
	output logic byte_stb_out,
	output logic [7:0] byte_out,
	output logic gap_short_out
);
	logic lvl_q, zero_q, pb_q, st_q, bit_w;
	logic [7:0] sh_q;
	int t_q, nb_q;
	assign side_out = 1'b1;
	assign write_enable_n_out = 1'b0;
	assign ready_n_out = !(lock_in && select_in);
	assign tape_end_n_out = 1'b1;
	// no playback, so no flux changes
	assign read_data_line_out = 1'b0;
	assign bit_w = write_data_line_in != zero_q;
	always @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lvl_q <= 1'b1;
			{zero_q, pb_q, st_q, byte_stb_out, gap_short_out} <= 5'h00;
			{sh_q, byte_out} <= 16'h0000;
			t_q <= GAP;
			nb_q <= 0;
		end else begin
			byte_stb_out <= 1'b0;
			lvl_q <= write_data_line_in;
			t_q <= t_q + 1;
			if (write_data_line_in != lvl_q) begin
				t_q <= 1;
				// preamble has no phase changes, so a short step after a start redoes it
				if (t_q > 3 * HALF || (st_q && 2 * t_q < 3 * HALF)) begin
					gap_short_out <= gap_short_out || (t_q > 3 * HALF && t_q < GAP);
					zero_q <= write_data_line_in;
					{pb_q, st_q, sh_q} <= 10'h300;
					nb_q <= 1;
				end else if (2 * t_q >= 3 * HALF || !pb_q) begin
					{pb_q, st_q} <= 2'h2;
					sh_q <= {bit_w, sh_q[7:1]};
					byte_out <= {bit_w, sh_q[7:1]};
					byte_stb_out <= nb_q == 7;
					nb_q <= (nb_q + 1) % 8;
				end else begin
					{pb_q, st_q} <= 2'h0;
				end
			end
		end
	end
endmodule // cti_drive_model
`default_nettype wire

// ### dv/tb.sv
// bench: host cycles, block writes checked through the drive model
`default_nettype none
`include "cti_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] DEV = 5'h05;
	logic sys_clk_in = 1'b0, reset_n_in = 1'b0, op_request_n_in = 1'b1, ext_io_sel_n_in = 1'b1, tape_mark_in = 1'b0;
	logic [7:0] host_addr_lo_in = 8'h00, host_data_in = 8'h00, block_count_in = 8'h02, rd, e8, lfsr_q = 8'h0b;
	logic [8:0] first_len_in = 9'h002;
	logic [15:0] crc;
	logic acked;
	wire op_ack_n_out, irq_n_out, host_data_oe_out, cassette_lock_out, drive_select_out, tape_forward_out;
	wire tape_backward_out, write_command_out, read_gate_out, tape_rewind_out, write_data_line_out, crc_error_out;
	wire busy_out, side_indicator_in, write_enable_n_in, ready_n_in, tape_end_marker_n_in, read_data_line_in, stb, gshort;
	wire [7:0] host_data_out, bval;
	int mismatches = 0, checked = 0, n;
	logic [7:0] exp_q[$];
	cti_top #(.DEV_ADDR(DEV), .GAP_CYC(200), .HALF_CYC(8), .MASK_CYC(12)) cti_top_inst (.*);
	cti_drive_model #(.HALF(8), .GAP(200)) cti_drive_model_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.lock_in(cassette_lock_out), .select_in(drive_select_out), .write_data_line_in(write_data_line_out),
		.side_out(side_indicator_in), .write_enable_n_out(write_enable_n_in), .ready_n_out(ready_n_in),
		.tape_end_n_out(tape_end_marker_n_in), .read_data_line_out(read_data_line_in), .byte_stb_out(stb),
		.byte_out(bval), .gap_short_out(gshort));
	always #25 sys_clk_in = ~sys_clk_in;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// bits enter in tape order
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `CTI_CRC_POLY : 16'h0000);
		return c;
	endfunction
	task automatic final_report;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic expire(input int lim);
		if (n >= lim) begin
			mismatches++;
			final_report;
		end
	endtask
	// request held past the data edge, then one idle edge
	task automatic op(input logic [2:0] cmd, input logic [4:0] pa, input logic [7:0] d, input logic ext);
		op_request_n_in <= 1'b0;
		ext_io_sel_n_in <= !ext;
		host_addr_lo_in <= {cmd, pa};
		host_data_in <= d;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (op_ack_n_out !== 1'b0 && n < 4);
		acked = op_ack_n_out === 1'b0;
		repeat (2) @(posedge sys_clk_in);
		rd = host_data_out;
		op_request_n_in <= 1'b1;
		ext_io_sel_n_in <= 1'b1;
		@(posedge sys_clk_in);
	endtask
	task automatic push_tail;
		exp_q.push_back(crc[15:8]);
		exp_q.push_back(crc[7:0]);
		exp_q.push_back(`CTI_FRAME_BYTE);
	endtask
	always @(posedge sys_clk_in) begin
		if (stb === 1'b1) begin
			e8 = exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx;
			`CHK(bval, e8)
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		`CHK({irq_n_out, op_ack_n_out, cassette_lock_out, write_data_line_out}, 4'b1101)
		op(`CTI_CMD_STATUS, DEV ^ 5'h10, 8'h00, 1'b1);
		`CHK(acked, 1'b0)
		op(`CTI_CMD_STATUS, DEV, 8'h00, 1'b0);
		`CHK(acked, 1'b0)
		op(`CTI_CMD_STATUS, DEV, 8'h00, 1'b1);
		`CHK({acked, rd[7], rd[1:0]}, 4'b1101)
		op(`CTI_CMD_CONNECT, DEV, 8'h24, 1'b1);
		`CHK({cassette_lock_out, tape_forward_out, write_command_out}, 3'b111)
		exp_q.push_back(`CTI_FRAME_BYTE);
		crc = `CTI_CRC_INIT;
		// short first block, then one full block; the fifo fills while the tape runs
		for (int i = 0; i < 258; i++) begin
			if (i == 2) begin
				push_tail;
				exp_q.push_back(`CTI_FRAME_BYTE);
				crc = `CTI_CRC_INIT;
			end
			n = 0;
			while (busy_out !== 1'b0 && n < 2000) begin
				@(posedge sys_clk_in);
				n++;
			end
			expire(2000);
			lfsr_q = lfsr(lfsr_q);
			crc = crc_upd(crc, lfsr_q);
			exp_q.push_back(lfsr_q);
			op(`CTI_CMD_OUT_XCHG, DEV, lfsr_q, 1'b1);
		end
		push_tail;
		n = 0;
		while (exp_q.size() != 0 && n < 60000) begin
			@(posedge sys_clk_in);
			n++;
		end
		expire(60000);
		`CHK({irq_n_out, gshort}, 2'b00)
		op(`CTI_CMD_DISCONNECT, DEV, 8'h00, 1'b1);
		`CHK({acked, tape_forward_out, write_command_out}, 3'b100)
		final_report;
	end
endmodule // tb
`default_nettype wire
